/* hw/host_ctl_pkg.sv */
package host_ctl_pkg;

	// host register indices; reset control and error status share host word 0
	localparam logic [1:0] ADDR_RESET_CTL = 2'h0;
	localparam logic [1:0] ADDR_ERROR_STS = 2'h0;
	localparam logic [1:0] ADDR_ANALYSE_CTL = 2'h1;
	localparam logic [1:0] ADDR_IRQ_ENABLE = 2'h2;
	localparam logic [1:0] ADDR_IRQ_STATUS = 2'h3;

	localparam int DATA_W = 8;
	localparam int IRQ_N = 4;

	// field positions
	localparam int LATCH_BIT = 0;
	localparam int IRQ_TX_DONE = 0;
	localparam int IRQ_RX_DONE = 1;
	localparam int IRQ_FAULT = 2;
	localparam int IRQ_DMA_DONE = 3;

	// reset values
	localparam logic RESET_LATCH_RST = 1'b0;
	localparam logic ANALYSE_LATCH_RST = 1'b0;
	localparam logic [IRQ_N-1:0] IRQ_ENABLE_RST = 4'h0;
	localparam logic [IRQ_N-1:0] IRQ_PEND_RST = 4'h0;

	// board control source select
	typedef enum logic {
		SRC_UP = 1'b0,
		SRC_HOST = 1'b1
	} ctl_src_e;

endpackage

/* hw/ctl_route.sv */
`timescale 1ns/1ps
// one active-low control line: upstream or host latch, registered
module ctl_route
	import host_ctl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// sources
	input wire logic sel,
	input wire logic up_n,
	input wire logic host_n,
	// routed line
	output logic line_n
);

	typedef struct packed {
		logic line_n;
	} route_s;

	route_s st_r;
	route_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.line_n = (ctl_src_e'(sel) == SRC_HOST) ? host_n : up_n;
	end

	// released while in reset: lines idle high
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '{line_n: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign line_n = st_r.line_n;

endmodule // ctl_route

/* hw/host_subsystem_control.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - host serial data path joins link zero of slot zero only.
// - two host latches drive reset and analyse lines; the error line is sensed, not latched.
// - reset and analyse latches sit at consecutive host addresses.
// - reset and analyse latches are write only; reads unsupported.
// - error status reads at the reset latch address; writes go to reset.
// - bit 0 one drives host reset low; zero releases it.
// - bit 0 one drives host analyse low; zero releases it.
// - error read bit 0 is one while fault line is low.
// - link adapter reset follows whichever source resets slot zero.
// - interrupt on completion of host to board transfer.
// - interrupt on completion of board to host transfer.
// - interrupt when the host fault line becomes asserted.
// - interrupt may also be raised at end of a dma cycle.
// - host writable enable bits select interrupting conditions.
// - readable status shows which condition is pending.
// - selector routes slot zero and down reset and analyse.
// - all control port reset, analyse and error lines active low.
module host_subsystem_control
	import host_ctl_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host register port
	input wire logic [1:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [DATA_W-1:0] host_wdata,
	output logic [DATA_W-1:0] host_rdata,
	output logic host_irq,
	// link adapter events and serial link
	input wire logic link_tx_done,
	input wire logic link_rx_done,
	input wire logic dma_done,
	input wire logic host_link_out,
	output logic host_link_in,
	output logic link_adapter_reset_n,
	// slot zero link zero
	input wire logic slot0_link0_out,
	output logic slot0_link0_in,
	// host control port
	output logic host_ctl_reset_n,
	output logic host_ctl_halt_inspect_n,
	input wire logic host_ctl_fault_n,
	// upstream port and board control select
	input wire logic up_reset_n,
	input wire logic up_analyse_n,
	input wire logic board_sel,
	// slot zero and downstream port
	output logic slot0_reset_n,
	output logic slot0_analyse_n,
	output logic down_reset_n,
	output logic down_analyse_n
);

	//////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic reset_lat;
		logic analyse_lat;
		logic [IRQ_N-1:0] irq_en;
		logic [IRQ_N-1:0] irq_pend;
		logic fault_prev;
		logic [DATA_W-1:0] rdata;
		logic to_slot;
		logic to_host;
	} ctl_s;

	ctl_s st_r;
	ctl_s st_nxt;

	logic [IRQ_N-1:0] irq_evt;
	logic [1:0] host_n;
	logic [1:0] up_n;
	logic [1:0] routed_n;

	function automatic logic hit(input logic [1:0] a, input logic [1:0] idx);
		hit = (a == idx);
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt = st_r;
		irq_evt = '0;
		irq_evt[IRQ_TX_DONE] = link_tx_done;
		irq_evt[IRQ_RX_DONE] = link_rx_done;
		// fault edge only, so a held fault cannot re-raise after acknowledge
		irq_evt[IRQ_FAULT] = st_r.fault_prev & ~host_ctl_fault_n;
		irq_evt[IRQ_DMA_DONE] = dma_done;
		st_nxt.fault_prev = host_ctl_fault_n;

		// link bits retimed once; adds one cycle of latency each way
		st_nxt.to_slot = host_link_out;
		st_nxt.to_host = slot0_link0_out;

		if (host_wr) begin
			if (hit(host_addr, ADDR_RESET_CTL)) begin
				st_nxt.reset_lat = host_wdata[LATCH_BIT];
			end
			if (hit(host_addr, ADDR_ANALYSE_CTL)) begin
				st_nxt.analyse_lat = host_wdata[LATCH_BIT];
			end
			if (hit(host_addr, ADDR_IRQ_ENABLE)) begin
				st_nxt.irq_en = host_wdata[IRQ_N-1:0];
			end
			if (hit(host_addr, ADDR_IRQ_STATUS)) begin
				// write one to acknowledge
				st_nxt.irq_pend = st_r.irq_pend & ~host_wdata[IRQ_N-1:0];
			end
		end
		// a new event beats a same-cycle acknowledge
		st_nxt.irq_pend = st_nxt.irq_pend | irq_evt;

		if (host_rd) begin
			st_nxt.rdata = '0;
			unique case (host_addr)
				ADDR_ERROR_STS: begin
					st_nxt.rdata[LATCH_BIT] = ~host_ctl_fault_n;
				end
				ADDR_ANALYSE_CTL: begin
					st_nxt.rdata = '0;
				end
				ADDR_IRQ_ENABLE: begin
					st_nxt.rdata[IRQ_N-1:0] = st_r.irq_en;
				end
				ADDR_IRQ_STATUS: begin
					st_nxt.rdata[IRQ_N-1:0] = st_r.irq_pend;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '{
				reset_lat: RESET_LATCH_RST,
				analyse_lat: ANALYSE_LATCH_RST,
				irq_en: IRQ_ENABLE_RST,
				irq_pend: IRQ_PEND_RST,
				fault_prev: 1'b1,
				rdata: '0,
				to_slot: 1'b1,
				to_host: 1'b1
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// control routing

	assign host_n = {~st_r.analyse_lat, ~st_r.reset_lat};
	assign up_n = {up_analyse_n, up_reset_n};

	// index 0 reset, index 1 analyse
	generate
		for (genvar i = 0; i < 2; i++) begin : g_route
			ctl_route u_route (
				.clk(clk),
				.rst(rst),
				.sel(board_sel),
				.up_n(up_n[i]),
				.host_n(host_n[i]),
				.line_n(routed_n[i])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// outputs

	assign host_ctl_reset_n = ~st_r.reset_lat;
	assign host_ctl_halt_inspect_n = ~st_r.analyse_lat;
	assign slot0_reset_n = routed_n[0];
	assign down_reset_n = routed_n[0];
	assign slot0_analyse_n = routed_n[1];
	assign down_analyse_n = routed_n[1];
	assign link_adapter_reset_n = routed_n[0];
	assign host_rdata = st_r.rdata;
	assign host_irq = |(st_r.irq_pend & st_r.irq_en);
	assign slot0_link0_in = st_r.to_slot;
	assign host_link_in = st_r.to_host;

endmodule // host_subsystem_control

/* bench/host_subsystem_control_asserts.sv */
`timescale 1ns/1ps
module host_ctl_checker
	import host_ctl_pkg::*;
(
	input wire logic clk, rst, host_wr, host_rd, host_irq, link_tx_done,
	input wire logic [1:0] host_addr,
	input wire logic [DATA_W-1:0] host_wdata, host_rdata,
	input wire logic host_ctl_reset_n, host_ctl_halt_inspect_n,
	input wire logic host_ctl_fault_n, board_sel, up_reset_n, slot0_reset_n,
	input wire logic link_adapter_reset_n, host_link_out, slot0_link0_in
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire wr0 = host_wr && host_addr == 2'h0;
	wire en0 = host_wr && host_addr == 2'h2 && host_wdata[0];
	////////////////////////////////////////
	property p_rst; wr0 |=> host_ctl_reset_n == !$past(host_wdata[0]);
	endproperty
	a_rst: assert property (p_rst) else $error("reset line");
	property p_ana; host_wr && host_addr == 2'h1 |=>
		host_ctl_halt_inspect_n == !$past(host_wdata[0]); endproperty
	a_ana: assert property (p_ana) else $error("halt line");
	property p_err; host_rd && host_addr == 2'h0 |=>
		host_rdata == {7'h00, !$past(host_ctl_fault_n)}; endproperty
	a_err: assert property (p_err) else $error("error read");
	property p_lnk; 1'b1 |=> slot0_link0_in == $past(host_link_out);
	endproperty
	a_lnk: assert property (p_lnk) else $error("link path");
	property p_sel; 1'b1 |=> slot0_reset_n == ($past(board_sel) ?
		$past(host_ctl_reset_n) : $past(up_reset_n)); endproperty
	a_sel: assert property (p_sel) else $error("slot0 reset");
	property p_lar; 1'b1 |=> link_adapter_reset_n == ($past(board_sel) ?
		$past(host_ctl_reset_n) : $past(up_reset_n)); endproperty
	a_lar: assert property (p_lar) else $error("adapter reset");
	// a mask write two cycles ahead must not hide the event
	property p_irq; en0 ##2 link_tx_done |=> host_irq; endproperty
	a_irq: assert property (p_irq) else $error("tx irq");
	property p_hld; host_irq && !host_wr |=> host_irq; endproperty
	a_hld: assert property (p_hld) else $error("irq hold");
endmodule // host_ctl_checker
bind host_subsystem_control host_ctl_checker host_ctl_checker_inst (.*);

/* bench/host_bus_model.sv */
`timescale 1ns/1ps
// host cpu: one strobe per access, write data inverted after
module host_bus_model
	import host_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic [DATA_W-1:0] rdata,
	output logic [1:0] addr,
	output logic wr, rd,
	output logic [DATA_W-1:0] wdata
);
	initial {addr, wr, rd, wdata} = '0;
	task automatic put(logic [1:0] a, logic [7:0] v);
		@(posedge clk) #1 {addr, wdata, wr} = {a, v, 1'b1};
		@(posedge clk) #1 {wr, wdata} = {1'b0, ~v};
	endtask
	task automatic get(logic [1:0] a, output logic [7:0] v);
		@(posedge clk) #1 {addr, rd} = {a, 1'b1};
		@(posedge clk) #1 rd = 0;
		v = rdata;
	endtask
endmodule // host_bus_model

/* bench/host_subsystem_control_tb_top.sv */
`timescale 1ns/1ps
module host_subsystem_control_tb_top
	import host_ctl_pkg::*;
;
	logic clk = 0, rst = 1, board_sel, up_reset_n, up_analyse_n;
	logic host_link_out, slot0_link0_out, host_wr, host_rd, host_irq;
	logic link_tx_done, link_rx_done, dma_done, host_ctl_fault_n;
	logic host_link_in, link_adapter_reset_n, slot0_link0_in;
	logic host_ctl_reset_n, host_ctl_halt_inspect_n, slot0_reset_n;
	logic slot0_analyse_n, down_reset_n, down_analyse_n;
	logic [1:0] host_addr;
	logic [7:0] host_wdata, host_rdata, d, b = 8'hff;
	logic [3:0] ev = 4'h4;
	int bad_count = 0, comparisons = 0, s = 31, rl = 0, al = 0;
	assign {dma_done, host_ctl_fault_n, link_rx_done, link_tx_done} = ev;
	assign {board_sel, up_reset_n, up_analyse_n} = b[4:2];
	assign {host_link_out, slot0_link0_out} = b[1:0];
	always #5 clk = ~clk;
	host_subsystem_control host_subsystem_control_inst (.clk, .rst,
		.host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata, .host_irq,
		.link_tx_done, .link_rx_done, .dma_done, .host_link_out, .host_link_in,
		.link_adapter_reset_n, .slot0_link0_out, .slot0_link0_in,
		.host_ctl_reset_n, .host_ctl_halt_inspect_n, .host_ctl_fault_n,
		.up_reset_n, .up_analyse_n, .board_sel, .slot0_reset_n,
		.slot0_analyse_n, .down_reset_n, .down_analyse_n);
	host_bus_model host_bus_model_inst (.clk, .rdata(host_rdata),
		.addr(host_addr), .wr(host_wr), .rd(host_rd), .wdata(host_wdata));
	////////////////////////////////////////
	function automatic int nx();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 0;
		chk("reset idle", 1, host_ctl_reset_n);
		chk("irq idle", 0, host_irq);
		repeat (12) begin
			d = 8'(nx());
			b = 8'(nx());
			ev[2] = d[4];
			host_bus_model_inst.put({1'b0, d[1]}, d);
			if (d[1]) al = d[0];
			else rl = d[0];
			host_bus_model_inst.get(2'h0, d);
			chk("error", {7'h0, !ev[2]}, d);
			chk("reset", !rl, host_ctl_reset_n);
			chk("halt", !al, host_ctl_halt_inspect_n);
			chk("slot0", b[4] ? !rl : b[3], slot0_reset_n);
			chk("down", b[4] ? !al : b[2], down_analyse_n);
			chk("adapter", b[4] ? !rl : b[3], link_adapter_reset_n);
			chk("slot0 ana", b[4] ? !al : b[2], slot0_analyse_n);
			chk("down rst", b[4] ? !rl : b[3], down_reset_n);
			chk("link", b[1:0], {slot0_link0_in, host_link_in});
		end
		host_bus_model_inst.get(2'h1, d);
		chk("analyse read", 0, d);
		host_bus_model_inst.put(2'h2, 8'h0a);
		host_bus_model_inst.get(2'h2, d);
		chk("enable read", 8'h0a, d);
		// fault noise from above left bits pending: clear all first
		ev = 4'h4;
		host_bus_model_inst.put(2'h3, 8'h0f);
		for (int i = 0; i < 8; i++) begin
			host_bus_model_inst.put(2'h2, i < 4 ? 8'h0f : 8'h00);
			@(posedge clk) #1 ev = 4'h4 ^ (4'h1 << i % 4);
			@(posedge clk) #1 ev = 4'h4;
			host_bus_model_inst.get(2'h3, d);
			chk("status", 8'h01 << i % 4, d);
			chk("irq", i < 4, host_irq);
			host_bus_model_inst.put(2'h3, 8'h01 << i % 4);
			chk("irq clear", 0, host_irq);
		end
		finish_test();
	end
endmodule // host_subsystem_control_tb_top
